/* core/qdm_consts.svh */
// Constants for the quadrature decoder pin multiplexer
`ifndef QDM_CONSTS_SVH
`define QDM_CONSTS_SVH

// Port C pull-up enable register
`define QDM_PU_WIDTH 16
`define QDM_PU_PHASE_B_BIT 1
`define QDM_PU_IDX_BIT 2
`define QDM_PU_RESET 16'hFFFF

// Reset values of the per-pin selection fields
`define QDM_SEL_RESET 1'h0
`define QDM_DIR_RESET 1'h0
`define QDM_DOUT_RESET 1'h0

// Pad and routed-input values while in reset
`define QDM_OE_RESET 1'h0
`define QDM_PAD_OUT_RESET 1'h0
`define QDM_PULL_RESET 1'h1
`define QDM_IN_RESET 1'h1
`define QDM_IDLE_LEVEL 1'h1

// SPI data path idle values
`define QDM_BIT_RESET 1'h0
`define QDM_SCK_RESET 1'h0
`define QDM_SS_N_RESET 1'h1

`endif

/* core/qdm_pin_cell.sv */
// One shared pin: output steering and input routing per function
`timescale 1ns/10ps
`include "qdm_consts.svh"

module qdm_pin_cell (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Selection
    input qdm_pkg::qdm_fn_e fn,
    input wire logic pull_en,
    input wire logic gpio_dir,
    input wire logic gpio_dout,
    // Peripheral drive
    input wire logic tmr_out,
    input wire logic tmr_oe,
    input wire logic spi_out,
    input wire logic spi_oe,
    // Pad
    input wire logic pin_in,
    output qdm_pkg::qdm_pad_s pad,
    // Routed inputs
    output logic quad_in,
    output logic tmr_in,
    output logic spi_in,
    output logic gpio_in
);
    import qdm_pkg::*;

    wire is_quad = (fn == QDM_FN_QUAD);
    wire is_tmr = (fn == QDM_FN_TIMER);
    wire is_spi = (fn == QDM_FN_SPI);
    wire is_gpio = (fn == QDM_FN_GPIO);

    // Only the chosen function may drive; quadrature is input only
    wire next_oe = (is_tmr & tmr_oe) | (is_spi & spi_oe) |
                   (is_gpio & gpio_dir);
    wire next_dout = is_tmr ? tmr_out :
                     is_spi ? spi_out :
                     is_gpio ? gpio_dout : `QDM_PAD_OUT_RESET;

    // Unselected consumers see the idle (pulled-up) level
    wire next_quad = is_quad ? pin_in : `QDM_IDLE_LEVEL;
    wire next_tmr = is_tmr ? pin_in : `QDM_IDLE_LEVEL;
    wire next_spi = is_spi ? pin_in : `QDM_IDLE_LEVEL;
    wire next_gpio = is_gpio ? pin_in : `QDM_IDLE_LEVEL;

    // Pad drive, pull-up and routed inputs are all registered
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pad.oe <= `QDM_OE_RESET;
            pad.dout <= `QDM_PAD_OUT_RESET;
            pad.pull <= `QDM_PULL_RESET;
            quad_in <= `QDM_IN_RESET;
            tmr_in <= `QDM_IN_RESET;
            spi_in <= `QDM_IN_RESET;
            gpio_in <= `QDM_IN_RESET;
        end else begin
            pad.oe <= next_oe;
            pad.dout <= next_dout;
            pad.pull <= pull_en;
            quad_in <= next_quad;
            tmr_in <= next_tmr;
            spi_in <= next_spi;
            gpio_in <= next_gpio;
        end
    end

endmodule

/* core/qdm_pin_mux.sv */
// Pin multiplexer for the phase-B and index pins of port C
//
// How it works
// - Full variant: phase-B pin feeds decoder 1 phase B after reset.
// - Full variant: index pin feeds decoder 1 index after reset.
// - Quadrature function selected: phase-B pin drives decoder 1 phase B.
// - Quadrature function selected: index pin drives decoder 1 index.
// - Reduced variant: no function after reset until software chooses.
// - Phase-B alternate bit set connects pin to serial MOSI unless GPIO mode is also set.
// - Index alternate bit set connects pin to serial MISO unless GPIO mode is also set.
// - Clearing pull-up bit 1 disables the phase-B pull-up.
// - Clearing pull-up bit 2 disables the index pull-up.
// - In GPIO mode each pin has its own direction.
// - Master drives MOSI half a clock before the slave samples.
// - Slave drives MISO half a clock before the master samples.
// - Slave MISO is released whenever slave select is not asserted.
// - Slave treats asserted slave select as transfer addressed to it.
`timescale 1ns/10ps
`include "qdm_consts.svh"

module qdm_pin_mux #(
    parameter bit FULL_VARIANT = 1'b1,
    parameter int PU_W = `QDM_PU_WIDTH
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,

    // Configuration, loaded on cfg_wr
    input wire logic cfg_wr,
    input qdm_pkg::qdm_pin_cfg_s cfg_phase_b,
    input qdm_pkg::qdm_pin_cfg_s cfg_idx,
    input wire logic [PU_W-1:0] cfg_pullup,

    // Status
    output qdm_pkg::qdm_fn_e phase_b_fn,
    output qdm_pkg::qdm_fn_e idx_fn,
    output logic mux_live,
    output logic [1:0] pin_select_register,

    // Phase-B pad
    input wire logic phase_b_pin_in,
    output logic phase_b_pin_out,
    output logic phase_b_pin_oe,
    output logic phase_b_pullup,

    // Index pad
    input wire logic idx_pin_in,
    output logic idx_pin_out,
    output logic idx_pin_oe,
    output logic idx_pullup,

    // Quadrature decoder 1 inputs
    output logic quad_phase_b_in,
    output logic quad_idx_in,

    // Timer B channels 1 and 2
    input wire logic timer_b_chan_one_out,
    input wire logic timer_b_chan_one_oe,
    output logic timer_b_chan_one_in,
    input wire logic timer_b_chan_two_out,
    input wire logic timer_b_chan_two_oe,
    output logic timer_b_chan_two_in,

    // Port C general-purpose inputs
    output logic port_c_line_one,
    output logic port_c_line_two,

    // Serial interface 1 data path
    input wire logic spi_master,
    input wire logic spi_cpol,
    input wire logic spi_sck,
    input wire logic spi_ss_n,
    input wire logic spi_tx_bit,
    output logic spi_tx_take,
    output logic spi_rx_bit,
    output logic spi_rx_valid,
    output logic spi_addressed
);
    import qdm_pkg::*;

    // Configuration registers
    qdm_pin_cfg_s cfg_b;
    qdm_pin_cfg_s cfg_i;
    logic [PU_W-1:0] port_c_pullup_enable;
    qdm_st_e state;
    qdm_st_e next_state;

    // SPI sampling registers
    logic sck_q;
    logic sck_prev;
    logic ss_n_q;
    logic ss_n_prev;
    logic tx_q;

    // Per-pin routed SPI inputs from the cells
    logic b_spi_in;
    logic i_spi_in;

    // Named views of the alternate-select bits
    wire phase_b_spi_select = cfg_b.spi_alt;
    wire idx_spi_select = cfg_i.spi_alt;

    // Reduced variant waits for a first configuration write
    always_comb begin
        next_state = state;
        case (state)
            QDM_ST_UNSET: begin
                if (cfg_wr) begin
                    next_state = QDM_ST_LIVE;
                end
            end
            QDM_ST_LIVE: begin
                next_state = QDM_ST_LIVE;
            end
            default: begin
                next_state = QDM_ST_UNSET;
            end
        endcase
    end

    // Full variant comes out of reset already live
    wire live = (state == QDM_ST_LIVE);
    wire next_live = (next_state == QDM_ST_LIVE);

    // Function decode, shared by both pins
    wire qdm_fn_e fn_b = qdm_pick_fn(live, cfg_b);
    wire qdm_fn_e fn_i = qdm_pick_fn(live, cfg_i);

    // Alternate bits clear at reset so quadrature is the default in the full variant
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cfg_b <= '0;
            cfg_i <= '0;
            port_c_pullup_enable <= PU_W'(`QDM_PU_RESET);
            state <= FULL_VARIANT ? QDM_ST_LIVE : QDM_ST_UNSET;
        end else begin
            if (cfg_wr) begin
                cfg_b <= cfg_phase_b;
                cfg_i <= cfg_idx;
                port_c_pullup_enable <= cfg_pullup;
            end
            state <= next_state;
        end
    end

    // Status flops; function code and select bits lag the configuration by one cycle
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            phase_b_fn <= QDM_FN_NONE;
            idx_fn <= QDM_FN_NONE;
            mux_live <= `QDM_SEL_RESET;
            pin_select_register <= '0;
        end else begin
            phase_b_fn <= fn_b;
            idx_fn <= fn_i;
            mux_live <= next_live;
            pin_select_register <= {idx_spi_select, phase_b_spi_select};
        end
    end

    // Pull-up enables come from their own bits of the port C register
    wire pull_b = port_c_pullup_enable[`QDM_PU_PHASE_B_BIT];
    wire pull_i = port_c_pullup_enable[`QDM_PU_IDX_BIT];

    // Clock and select sampled once; inputs are synchronous already
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            // Seed with the pin so an idle-high clock gives no false edge
            sck_q <= spi_sck;
            sck_prev <= spi_sck;
            ss_n_q <= `QDM_SS_N_RESET;
            ss_n_prev <= `QDM_SS_N_RESET;
        end else begin
            sck_q <= spi_sck;
            sck_prev <= sck_q;
            ss_n_q <= spi_ss_n;
            ss_n_prev <= ss_n_q;
        end
    end

    // Edge decode; polarity picks which edge samples and which launches
    wire sck_rise = sck_q & ~sck_prev;
    wire sck_fall = ~sck_q & sck_prev;
    wire sample_edge = spi_cpol ? sck_fall : sck_rise;
    wire launch_edge = spi_cpol ? sck_rise : sck_fall;
    wire ss_fall = ~ss_n_q & ss_n_prev;

    // A slave answers only while its select is asserted
    wire slave_sel = ~spi_master & ~ss_n_q;
    wire spi_active = spi_master | slave_sel;

    // New bit goes out on select fall or the launch edge, half a clock before sampling
    wire tx_load = spi_active & (launch_edge | ss_fall);
    wire rx_load = spi_active & sample_edge;

    // Master samples MISO, slave samples MOSI
    wire rx_src = spi_master ? i_spi_in : b_spi_in;

    // Outgoing and incoming serial bits
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tx_q <= `QDM_BIT_RESET;
            spi_tx_take <= `QDM_BIT_RESET;
            spi_rx_bit <= `QDM_BIT_RESET;
            spi_rx_valid <= `QDM_BIT_RESET;
            spi_addressed <= `QDM_BIT_RESET;
        end else begin
            if (tx_load) begin
                tx_q <= spi_tx_bit;
            end
            spi_tx_take <= tx_load;
            if (rx_load) begin
                spi_rx_bit <= rx_src;
            end
            spi_rx_valid <= rx_load;
            spi_addressed <= slave_sel;
        end
    end

    // MOSI is driven only by a master
    wire b_spi_oe = spi_master;
    // MISO stays released unless this slave is selected
    wire i_spi_oe = slave_sel;

    qdm_pad_s pad_b;
    qdm_pad_s pad_i;

    // Phase-B pin: quadrature phase B, timer channel 1, MOSI or GPIO
    qdm_pin_cell u_phase_b (
        .mclk(mclk),
        .nrst(nrst),
        .fn(fn_b),
        .pull_en(pull_b),
        .gpio_dir(cfg_b.dir),
        .gpio_dout(cfg_b.dout),
        .tmr_out(timer_b_chan_one_out),
        .tmr_oe(timer_b_chan_one_oe),
        .spi_out(tx_q),
        .spi_oe(b_spi_oe),
        .pin_in(phase_b_pin_in),
        .pad(pad_b),
        .quad_in(quad_phase_b_in),
        .tmr_in(timer_b_chan_one_in),
        .spi_in(b_spi_in),
        .gpio_in(port_c_line_one)
    );

    // Index pin: quadrature index, timer channel 2, MISO or GPIO
    qdm_pin_cell u_idx (
        .mclk(mclk),
        .nrst(nrst),
        .fn(fn_i),
        .pull_en(pull_i),
        .gpio_dir(cfg_i.dir),
        .gpio_dout(cfg_i.dout),
        .tmr_out(timer_b_chan_two_out),
        .tmr_oe(timer_b_chan_two_oe),
        .spi_out(tx_q),
        .spi_oe(i_spi_oe),
        .pin_in(idx_pin_in),
        .pad(pad_i),
        .quad_in(quad_idx_in),
        .tmr_in(timer_b_chan_two_in),
        .spi_in(i_spi_in),
        .gpio_in(port_c_line_two)
    );

    // Pad fields are flops inside the cells; these are plain wires
    assign phase_b_pin_out = pad_b.dout;
    assign phase_b_pin_oe = pad_b.oe;
    assign phase_b_pullup = pad_b.pull;
    assign idx_pin_out = pad_i.dout;
    assign idx_pin_oe = pad_i.oe;
    assign idx_pullup = pad_i.pull;

endmodule

/* core/qdm_pkg.sv */
// Types shared by the quadrature decoder pin multiplexer
package qdm_pkg;

    // Function currently given to a shared pin
    typedef enum logic [4:0] {
        QDM_FN_NONE  = 5'h01,
        QDM_FN_QUAD  = 5'h02,
        QDM_FN_TIMER = 5'h04,
        QDM_FN_SPI   = 5'h08,
        QDM_FN_GPIO  = 5'h10
    } qdm_fn_e;

    // Whether a function has been chosen since reset
    typedef enum logic [1:0] {
        QDM_ST_UNSET = 2'h1,
        QDM_ST_LIVE  = 2'h2
    } qdm_st_e;

    // Software selection for one pin
    typedef struct packed {
        logic spi_alt;
        logic timer_sel;
        logic gpio_mode;
        logic dir;
        logic dout;
    } qdm_pin_cfg_s;

    // What the pad cell receives
    typedef struct packed {
        logic dout;
        logic oe;
        logic pull;
    } qdm_pad_s;

    // GPIO wins over the alternate bit, which wins over the timer
    function automatic qdm_fn_e qdm_pick_fn(input logic live,
                                            input qdm_pin_cfg_s cfg);
        qdm_fn_e fn;
        fn = QDM_FN_QUAD;
        if (!live) begin
            fn = QDM_FN_NONE;
        end else if (cfg.gpio_mode) begin
            fn = QDM_FN_GPIO;
        end else if (cfg.spi_alt) begin
            fn = QDM_FN_SPI;
        end else if (cfg.timer_sel) begin
            fn = QDM_FN_TIMER;
        end
        return fn;
    endfunction

endpackage

/* dv/qdm_pin_mux_properties.sv */
// Concurrent checks on the port C pin multiplexer outputs
`timescale 1ns/10ps
module qdm_pin_mux_properties #(
    parameter bit FULL_VARIANT = 1'b1,
    parameter int PU_W = 16
) (
    // Clock, reset and configuration
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cfg_wr,
    input qdm_pkg::qdm_pin_cfg_s cfg_phase_b,
    input qdm_pkg::qdm_pin_cfg_s cfg_idx,
    input wire logic [PU_W-1:0] cfg_pullup,
    // Selection status and pads
    input qdm_pkg::qdm_fn_e phase_b_fn,
    input qdm_pkg::qdm_fn_e idx_fn,
    input wire logic [1:0] pin_select_register,
    input wire logic phase_b_pin_in,
    input wire logic phase_b_pin_oe,
    input wire logic phase_b_pullup,
    input wire logic idx_pin_in,
    input wire logic idx_pin_oe,
    input wire logic idx_pullup,
    input wire logic quad_phase_b_in,
    input wire logic quad_idx_in,
    // Serial interface controls
    input wire logic spi_master,
    input wire logic spi_ss_n,
    input wire logic spi_addressed
);
    import qdm_pkg::*;

    // One clock domain, so clock and reset are given once
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    // Function held two edges, so the input flop has seen it
    sequence b_quad_held;
        phase_b_fn == QDM_FN_QUAD ##1 phase_b_fn == QDM_FN_QUAD;
    endsequence
    sequence i_quad_held;
        idx_fn == QDM_FN_QUAD ##1 idx_fn == QDM_FN_QUAD;
    endsequence

    AST_RST_FN: assert property (
        $rose(nrst) |-> pin_select_register == 2'h0 ##[1:2]
            phase_b_fn == (FULL_VARIANT ? QDM_FN_QUAD : QDM_FN_NONE)
    ) else $error("wrong function after reset");
    AST_PU_B: assert property (
        cfg_wr |-> ##2 phase_b_pullup == $past(cfg_pullup[1], 2)
    ) else $error("phase-B pull-up wrong");
    AST_PU_I: assert property (
        cfg_wr |-> ##2 idx_pullup == $past(cfg_pullup[2], 2)
    ) else $error("index pull-up wrong");
    AST_SEL: assert property (
        cfg_wr |-> ##2 pin_select_register ==
            $past({cfg_idx.spi_alt, cfg_phase_b.spi_alt}, 2)
    ) else $error("select bits wrong");
    AST_SPI_B: assert property (
        cfg_wr && cfg_phase_b.spi_alt && !cfg_phase_b.gpio_mode
            |-> ##2 phase_b_fn == QDM_FN_SPI
    ) else $error("phase-B not on serial line");
    AST_GPIO_DIR: assert property (
        cfg_wr && cfg_phase_b.gpio_mode && cfg_idx.gpio_mode |-> ##2
            phase_b_pin_oe == $past(cfg_phase_b.dir, 2) &&
            idx_pin_oe == $past(cfg_idx.dir, 2)
    ) else $error("pin direction wrong");
    AST_QUAD_B: assert property (
        b_quad_held |-> quad_phase_b_in == $past(phase_b_pin_in)
    ) else $error("phase-B not routed to decoder");
    AST_QUAD_I: assert property (
        i_quad_held |-> quad_idx_in == $past(idx_pin_in)
    ) else $error("index not routed to decoder");
    AST_MISO_OFF: assert property (
        (!spi_master && spi_ss_n && idx_fn == QDM_FN_SPI)[*3] |-> !idx_pin_oe
    ) else $error("unselected slave drives its output");
    AST_ADDR: assert property (
        (!spi_master && !spi_ss_n)[*3] |-> spi_addressed
    ) else $error("selected slave not addressed");
endmodule

bind qdm_pin_mux qdm_pin_mux_properties #(
    .FULL_VARIANT(FULL_VARIANT),
    .PU_W(PU_W)
) u_props (
    .mclk, .nrst, .cfg_wr, .cfg_phase_b, .cfg_idx, .cfg_pullup,
    .phase_b_fn, .idx_fn, .pin_select_register, .phase_b_pin_in,
    .phase_b_pin_oe, .phase_b_pullup, .idx_pin_in, .idx_pin_oe,
    .idx_pullup, .quad_phase_b_in, .quad_idx_in, .spi_master,
    .spi_ss_n, .spi_addressed
);

/* dv/qdm_pin_mux_tb_top.sv */
// Self-checking bench for the port C quadrature pin multiplexer
`timescale 1ns/10ps
module qdm_pin_mux_tb_top;
    import qdm_pkg::*;

    // One configuration and what it should give
    typedef struct {
        qdm_pin_cfg_s b;
        qdm_pin_cfg_s i;
        logic [15:0] pu;
        qdm_fn_e fb;
        qdm_fn_e fi;
        logic [3:0] pad;
    } qdm_row_s;
    qdm_row_s rows[5] = '{
        '{5'h00, 5'h00, 16'hFFFF, QDM_FN_QUAD, QDM_FN_QUAD, 4'h0},
        '{5'h08, 5'h08, 16'hFFFF, QDM_FN_TIMER, QDM_FN_TIMER, 4'hC},
        '{5'h10, 5'h10, 16'hFFF9, QDM_FN_SPI, QDM_FN_SPI, 4'h0},
        '{5'h07, 5'h14, 16'hFFFD, QDM_FN_GPIO, QDM_FN_GPIO, 4'hC},
        '{5'h06, 5'h04, 16'hFFFB, QDM_FN_GPIO, QDM_FN_GPIO, 4'h8}
    };

    // Stimulus and observed signals
    logic mclk = 1'b0, nrst = 1'b0, cfg_wr = 1'b0;
    qdm_pin_cfg_s cfg_phase_b = '0, cfg_idx = '0;
    logic [15:0] cfg_pullup = 16'hFFFF;
    qdm_fn_e phase_b_fn, idx_fn;
    logic mux_live, phase_b_pin_out, phase_b_pin_oe, phase_b_pullup;
    logic idx_pin_out, idx_pin_oe, idx_pullup, quad_phase_b_in, quad_idx_in;
    logic timer_b_chan_one_in, timer_b_chan_two_in, port_c_line_one;
    logic port_c_line_two, spi_tx_take, spi_rx_bit, spi_rx_valid;
    logic spi_addressed, sck, ss_n, dq, doe;
    logic [1:0] pin_select_register, t_out = 2'h1, t_oe = 2'h1;
    logic spi_master = 1'b0, spi_cpol = 1'b0, tb_b = 1'b1, tb_i = 1'b1;
    logic [7:0] p_tx = 8'h00, p_rx, d_tx = 8'h00, d_rx = 8'h00;
    logic [3:0] half = 4'h6;
    logic [2:0] tx_idx = 3'h7;
    int fails = 0, n_tests = 0;
    // Wire levels: design drive, then the peer, else the external level
    wire logic pb_w = phase_b_pin_oe ? phase_b_pin_out :
        (doe && !spi_master) ? dq : tb_b;
    wire logic ix_w = idx_pin_oe ? idx_pin_out :
        (doe && spi_master) ? dq : tb_i;
    wire logic spi_tx_bit = d_tx[tx_idx];

    always #12.5 mclk = ~mclk;

    // Feed bits on each take and collect received bits
    always @(negedge mclk) begin
        if (spi_tx_take) tx_idx <= tx_idx - 3'h1;
        if (spi_rx_valid) d_rx <= {d_rx[6:0], spi_rx_bit};
    end

    qdm_pin_mux dut (
        .mclk, .nrst, .cfg_wr, .cfg_phase_b, .cfg_idx, .cfg_pullup,
        .phase_b_fn, .idx_fn, .mux_live, .pin_select_register,
        .phase_b_pin_in(pb_w), .phase_b_pin_out, .phase_b_pin_oe,
        .phase_b_pullup, .idx_pin_in(ix_w), .idx_pin_out, .idx_pin_oe,
        .idx_pullup, .quad_phase_b_in, .quad_idx_in,
        .timer_b_chan_one_out(t_out[0]), .timer_b_chan_one_oe(t_oe[0]),
        .timer_b_chan_one_in, .timer_b_chan_two_out(t_out[1]),
        .timer_b_chan_two_oe(t_oe[1]), .timer_b_chan_two_in,
        .port_c_line_one, .port_c_line_two, .spi_master, .spi_cpol,
        .spi_sck(sck), .spi_ss_n(ss_n), .spi_tx_bit, .spi_tx_take,
        .spi_rx_bit, .spi_rx_valid, .spi_addressed
    );
    qdm_spi_peer u_peer (
        .mclk, .cpol(spi_cpol), .half, .tx_byte(p_tx),
        .din(spi_master ? pb_w : ix_w),
        .sck, .ss_n, .dq, .doe, .rx_byte(p_rx)
    );

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic [2:0] rt(input qdm_fn_e f, input logic w);
        return {f == QDM_FN_QUAD ? w : 1'b1, f == QDM_FN_TIMER ? w : 1'b1,
            f == QDM_FN_GPIO ? w : 1'b1};
    endfunction
    // Load both pins; outputs are settled two edges after the load
    task automatic cfg(input qdm_pin_cfg_s b, i, input logic [15:0] pu);
        cfg_phase_b = b;
        cfg_idx = i;
        cfg_pullup = pu;
        cfg_wr = 1'b1;
        cyc(1);
        cfg_wr = 1'b0;
        cyc(2);
    endtask
    task automatic do_reset(input int n);
        nrst = 1'b0;
        cyc(n);
        nrst = 1'b1;
        cyc(3);
        chk({phase_b_fn, idx_fn}, {QDM_FN_QUAD, QDM_FN_QUAD});
        chk(pin_select_register, 2'h0);
        chk({phase_b_pullup, idx_pullup, phase_b_pin_oe, idx_pin_oe}, 4'hC);
        chk(mux_live, 1'b1);
        $display("reset test done");
    endtask
    // One byte each way; m picks which end is master
    task automatic spi_run(input logic m, c, input logic [3:0] h);
        spi_master = m;
        spi_cpol = c;
        half = h;
        p_tx = 8'hA5 ^ {4'h0, h};
        d_tx = 8'h3C ^ {h, 4'h0};
        cfg(5'h10, 5'h10, 16'hFFFF);
        tx_idx = 3'h7;
        chk(idx_pin_oe, 1'b0);
        u_peer.frame();
        cyc(6);
        chk(d_rx, p_tx);
        chk(p_rx, d_tx);
        $display("serial test done, master %0d cpol %0d", m, c);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Reset first, then table rows, serial cases and a second reset
    initial begin
        do_reset(16);
        foreach (rows[k]) begin
            cfg(rows[k].b, rows[k].i, rows[k].pu);
            chk({phase_b_fn, idx_fn}, {rows[k].fb, rows[k].fi});
            chk(pin_select_register, {rows[k].i[4], rows[k].b[4]});
            chk({idx_pullup, phase_b_pullup}, rows[k].pu[2:1]);
            chk({phase_b_pin_oe, phase_b_pin_oe & phase_b_pin_out, idx_pin_oe,
                idx_pin_oe & idx_pin_out}, rows[k].pad);
            tb_b = 1'b0;
            tb_i = 1'b0;
            cyc(2);
            chk({quad_phase_b_in, timer_b_chan_one_in, port_c_line_one,
                quad_idx_in, timer_b_chan_two_in, port_c_line_two},
                {rt(rows[k].fb, pb_w), rt(rows[k].fi, ix_w)});
            tb_b = 1'b1;
            tb_i = 1'b1;
            $display("row %0d done", k);
        end
        spi_run(1'b0, 1'b0, 4'h6);
        spi_run(1'b1, 1'b0, 4'h9);
        spi_run(1'b0, 1'b1, 4'h7);
        spi_run(1'b1, 1'b1, 4'h5);
        do_reset(2);
        end_sim();
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        end_sim();
    end
endmodule

/* dv/qdm_spi_peer.sv */
// Behavioural serial peer for the shared data pins
`timescale 1ns/10ps
module qdm_spi_peer (
    // Clock and frame setup
    input wire logic mclk,
    input wire logic cpol,
    input wire logic [3:0] half,
    input wire logic [7:0] tx_byte,
    // Serial lines; din is the line the other end drives
    input wire logic din,
    output logic sck,
    output logic ss_n,
    output logic dq,
    output logic doe,
    output logic [7:0] rx_byte
);
    // Clock phase before polarity; idle level follows the polarity
    logic tog;
    assign sck = tog ^ cpol;

    // Idle: deselected, clock still, data line released
    initial begin
        tog = 1'b0;
        ss_n = 1'b1;
        dq = 1'b1;
        rx_byte = 8'h00;
    end

    // Our data line is driven only inside a selected frame
    assign doe = !ss_n;

    // One byte MSB first; a long half period plays a slow far end
    task automatic frame();
        ss_n <= 1'b0;
        for (int k = 7; k >= 0; k--) begin
            dq <= tx_byte[k];
            repeat (half) @(negedge mclk);
            tog <= 1'b1;
            rx_byte[k] <= din;
            repeat (half) @(negedge mclk);
            tog <= 1'b0;
        end
        repeat (half) @(negedge mclk);
        ss_n <= 1'b1;
    endtask
endmodule
